// ### rtl/wakeup_source_event_control.sv
`timescale 1ns/1ps

// Functional notes
// RULE1: wake sources come from byte three of the sixteen-byte idle command; the code takes them from byte index 2.
// RULE2: source bits 7:6 pick oscillator rate 32, 16, 8 or 4 kHz.
// RULE3: oscillator rate and enabled sources are kept in the source register.
// RULE4: cause register is updated at the moment the wait state is left.
// RULE5: cause register is readable by register read and sent in the idle reply.
// RULE6: source bit 4 enables wake on low serial-select pin.
// RULE7: source bit 3 enables wake on low interrupt-input pin; host should set it.
// RULE8: source bit 1 enables wake on tag detection; host sets it for calibration.
// RULE9: bit 0 enables timeout of limit times (period plus one) reference periods.
// RULE10: reference period is 256 oscillator periods.
// RULE11: host keeps sleep count limit strictly between 0x00 and 0x1F.
// RULE12: host sets timeout bit when using timer and during calibration.
// RULE13: idle reply codes are 0x02 for tag detection and 0x01 for timeout.
// RULE14: during calibration host holds lower threshold at zero, varies upper.
// RULE15: host first tries upper 0x00 expecting tag, then 0xFC expecting timeout.
// RULE16: host then steps upper by 0x80 down to 0x04, per returned event.
// RULE17: reference is last upper, or upper minus four after a timeout.
// RULE18: level inside the lower/upper window gives no tag detection.
// RULE19: host sets thresholds eight below and eight above the reference.
// RULE20: cause register holds only the waking source bit plus copied rate.
module wakeup_source_event_control #(
    parameter int unsigned LFO_DIV = wake_ctrl_pkg::LFO_BASE_DIV,
    parameter int unsigned REF_PERIODS = wake_ctrl_pkg::REF_LFO_PERIODS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire logic cmd_first,
    input wire logic [7:0] cmd_byte,
    input wire logic read_req,
    input wire logic [1:0] read_index,
    input wire logic serial_select_n,
    input wire logic irq_in_n,
    input wire logic [7:0] tag_level,
    output logic in_wait_state,
    output logic idle_reply_valid,
    output logic [7:0] idle_reply_byte,
    output logic read_valid,
    output logic [7:0] read_data,
    output logic [1:0] low_freq_osc_rate
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    wake_ctrl_pkg::pwr_state_type state_reg, state_next;
    logic [7:0] wake_source_config_reg, wake_source_config_next;
    logic [7:0] wake_cause_record_reg, wake_cause_record_next;
    logic [7:0] wake_period_setting_reg, wake_period_setting_next;
    logic [7:0] lower_detect_threshold_reg, lower_detect_threshold_next;
    logic [7:0] upper_detect_threshold_reg, upper_detect_threshold_next;
    logic [7:0] sleep_count_limit_reg, sleep_count_limit_next;
    logic [7:0] src_shadow_reg, src_shadow_next;
    logic [3:0] byte_idx_reg, byte_idx_next;
    logic frame_idle_reg, frame_idle_next;
    logic [15:0] lfo_cnt_reg, lfo_cnt_next;
    logic [8:0] ref_cnt_reg, ref_cnt_next;
    logic [8:0] period_cnt_reg, period_cnt_next;
    logic [7:0] sleep_cnt_reg, sleep_cnt_next;
    logic reply_valid_reg, reply_valid_next;
    logic [7:0] reply_byte_reg, reply_byte_next;
    logic rd_valid_reg, rd_valid_next;
    logic [7:0] rd_data_reg, rd_data_next;

    logic lfo_tick;
    logic ref_tick;
    logic trial;
    logic in_window;
    logic tag_hit;
    logic timeout_hit;
    logic [5:0] cause;
    logic [3:0] cur_idx;
    logic [15:0] lfo_limit;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // each step of the rate field halves the oscillator, so the divider doubles
    function automatic logic [15:0] lfo_div_for(input logic [1:0] rate);
        lfo_div_for = 16'(LFO_DIV) << rate; // RULE2
    endfunction : lfo_div_for

    // fixed priority when several sources fire in the same cycle, so the
    // record always names exactly one cause
    function automatic logic [5:0] pick_cause(
        input logic ss_w,
        input logic irq_w,
        input logic tag_w,
        input logic to_w
    );
        if (irq_w) begin
            pick_cause = wake_ctrl_pkg::CAUSE_IRQ_PIN;
        end else if (ss_w) begin
            pick_cause = wake_ctrl_pkg::CAUSE_SS_PIN;
        end else if (tag_w) begin
            pick_cause = wake_ctrl_pkg::CAUSE_TAG;
        end else if (to_w) begin
            pick_cause = wake_ctrl_pkg::CAUSE_TIMEOUT;
        end else begin
            pick_cause = 6'h00;
        end
    endfunction : pick_cause

    // ------------------------------------------------------------
    // sleep timing and wake decisions
    // ------------------------------------------------------------
    assign low_freq_osc_rate =
        wake_source_config_reg[wake_ctrl_pkg::FLD_RATE_HI:wake_ctrl_pkg::FLD_RATE_LO];
    assign lfo_limit = lfo_div_for(low_freq_osc_rate);
    assign lfo_tick = (state_reg == wake_ctrl_pkg::WAIT_EVENT)
        && (lfo_cnt_reg == lfo_limit - 16'h0001);
    assign ref_tick = lfo_tick && (ref_cnt_reg == 9'(REF_PERIODS - 1)); // RULE10
    // one detection trial at the end of every wake period
    assign trial = ref_tick && (period_cnt_reg == {1'b0, wake_period_setting_reg}); // RULE9
    assign in_window = (tag_level >= lower_detect_threshold_reg)
        && (tag_level < upper_detect_threshold_reg); // RULE18
    assign tag_hit = trial && !in_window
        && wake_source_config_reg[wake_ctrl_pkg::BIT_TAG]; // RULE8
    // the host keeps the limit nonzero; a zero limit wraps and times out only after 256 trials
    assign timeout_hit = trial && (sleep_cnt_reg + 8'h01 == sleep_count_limit_reg)
        && wake_source_config_reg[wake_ctrl_pkg::BIT_TIMEOUT]; // RULE9 RULE11
    assign cause = (state_reg == wake_ctrl_pkg::WAIT_EVENT) ? pick_cause(
        wake_source_config_reg[wake_ctrl_pkg::BIT_SS_PIN] && !serial_select_n, // RULE6
        wake_source_config_reg[wake_ctrl_pkg::BIT_IRQ_PIN] && !irq_in_n, // RULE7
        tag_hit,
        timeout_hit) : 6'h00;
    assign cur_idx = cmd_first ? 4'h0 : byte_idx_reg;

    always_comb begin
        state_next = state_reg;
        wake_source_config_next = wake_source_config_reg;
        wake_cause_record_next = wake_cause_record_reg;
        wake_period_setting_next = wake_period_setting_reg;
        lower_detect_threshold_next = lower_detect_threshold_reg;
        upper_detect_threshold_next = upper_detect_threshold_reg;
        sleep_count_limit_next = sleep_count_limit_reg;
        src_shadow_next = src_shadow_reg;
        byte_idx_next = byte_idx_reg;
        frame_idle_next = frame_idle_reg;
        lfo_cnt_next = 16'h0000;
        ref_cnt_next = 9'h000;
        period_cnt_next = 9'h000;
        sleep_cnt_next = 8'h00;
        reply_valid_next = 1'b0;
        reply_byte_next = reply_byte_reg;
        rd_valid_next = read_req;
        rd_data_next = rd_data_reg;
        if (read_req) begin
            case (read_index)
                wake_ctrl_pkg::REG_WAKE_SOURCE_CONFIG: rd_data_next = wake_source_config_reg;
                wake_ctrl_pkg::REG_WAKE_CAUSE_RECORD: begin
                    rd_data_next = wake_cause_record_reg; // RULE5
                end
                default: rd_data_next = 8'h00;
            endcase
        end
        case (state_reg)
            wake_ctrl_pkg::READY: begin
                // the command link is only listened to while awake
                if (cmd_valid) begin
                    byte_idx_next = cur_idx + 4'h1;
                    if (cur_idx == 4'h0) begin
                        frame_idle_next = (cmd_byte == wake_ctrl_pkg::IDLE_CODE);
                    end
                    if (cur_idx == 4'h0 || frame_idle_reg) begin
                        case (cur_idx)
                            wake_ctrl_pkg::IDX_SOURCE: src_shadow_next = cmd_byte; // RULE1
                            wake_ctrl_pkg::IDX_WAKE_PERIOD: wake_period_setting_next = cmd_byte;
                            wake_ctrl_pkg::IDX_LOWER_THR: lower_detect_threshold_next = cmd_byte;
                            wake_ctrl_pkg::IDX_UPPER_THR: upper_detect_threshold_next = cmd_byte;
                            wake_ctrl_pkg::IDX_SLEEP_LIMIT: begin
                                sleep_count_limit_next = cmd_byte;
                                // reserved source bits are forced to zero
                                wake_source_config_next = src_shadow_reg & 8'hDB; // RULE3
                                frame_idle_next = 1'b0;
                                state_next = wake_ctrl_pkg::WAIT_EVENT;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            wake_ctrl_pkg::WAIT_EVENT: begin
                lfo_cnt_next = lfo_tick ? 16'h0000 : lfo_cnt_reg + 16'h0001;
                ref_cnt_next = ref_tick ? 9'h000 : (lfo_tick ? ref_cnt_reg + 9'h001 : ref_cnt_reg);
                period_cnt_next = trial ? 9'h000
                    : (ref_tick ? period_cnt_reg + 9'h001 : period_cnt_reg);
                sleep_cnt_next = trial ? sleep_cnt_reg + 8'h01 : sleep_cnt_reg;
                byte_idx_next = 4'h0;
                if (cause != 6'h00) begin
                    wake_cause_record_next = {low_freq_osc_rate, cause}; // RULE4 RULE20
                    reply_byte_next = {low_freq_osc_rate, cause}; // RULE5 RULE13
                    reply_valid_next = 1'b1;
                    state_next = wake_ctrl_pkg::READY;
                end
            end
            default: state_next = wake_ctrl_pkg::READY;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= wake_ctrl_pkg::READY;
            wake_source_config_reg <= wake_ctrl_pkg::WAKE_SOURCE_CONFIG_RESET;
            wake_cause_record_reg <= wake_ctrl_pkg::WAKE_CAUSE_RECORD_RESET;
            wake_period_setting_reg <= 8'h00;
            lower_detect_threshold_reg <= 8'h00;
            upper_detect_threshold_reg <= 8'h00;
            sleep_count_limit_reg <= 8'h00;
            src_shadow_reg <= 8'h00;
            byte_idx_reg <= 4'h0;
            frame_idle_reg <= 1'b0;
            lfo_cnt_reg <= 16'h0000;
            ref_cnt_reg <= 9'h000;
            period_cnt_reg <= 9'h000;
            sleep_cnt_reg <= 8'h00;
            reply_valid_reg <= 1'b0;
            reply_byte_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            wake_source_config_reg <= wake_source_config_next;
            wake_cause_record_reg <= wake_cause_record_next;
            wake_period_setting_reg <= wake_period_setting_next;
            lower_detect_threshold_reg <= lower_detect_threshold_next;
            upper_detect_threshold_reg <= upper_detect_threshold_next;
            sleep_count_limit_reg <= sleep_count_limit_next;
            src_shadow_reg <= src_shadow_next;
            byte_idx_reg <= byte_idx_next;
            frame_idle_reg <= frame_idle_next;
            lfo_cnt_reg <= lfo_cnt_next;
            ref_cnt_reg <= ref_cnt_next;
            period_cnt_reg <= period_cnt_next;
            sleep_cnt_reg <= sleep_cnt_next;
            reply_valid_reg <= reply_valid_next;
            reply_byte_reg <= reply_byte_next;
            rd_valid_reg <= rd_valid_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign in_wait_state = (state_reg == wake_ctrl_pkg::WAIT_EVENT);
    assign idle_reply_valid = reply_valid_reg;
    assign idle_reply_byte = reply_byte_reg;
    assign read_valid = rd_valid_reg;
    assign read_data = rd_data_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence idle_last_byte_s;
        cmd_valid && !cmd_first && frame_idle_reg
            && (byte_idx_reg == wake_ctrl_pkg::IDX_SLEEP_LIMIT)
            && (state_reg == wake_ctrl_pkg::READY);
    endsequence

    sequence wake_s;
        (state_reg == wake_ctrl_pkg::WAIT_EVENT) ##1 (state_reg == wake_ctrl_pkg::READY);
    endsequence

    src_capture_a: assert property ( // RULE1
        idle_last_byte_s |=> in_wait_state
            && wake_source_config_reg == ($past(src_shadow_reg) & 8'hDB))
        else $error("source byte not taken from idle command");

    source_hold_a: assert property ( // RULE3
        in_wait_state ##1 in_wait_state |-> $stable(wake_source_config_reg))
        else $error("source register changed while waiting");

    cause_update_a: assert property ( // RULE4
        wake_s |-> idle_reply_valid && (wake_cause_record_reg[5:0] != 6'h00)
            && (wake_cause_record_reg[7:6] == low_freq_osc_rate))
        else $error("cause record not refreshed on wake");

    reply_match_a: assert property ( // RULE5
        idle_reply_valid |-> idle_reply_byte == wake_cause_record_reg && !in_wait_state)
        else $error("idle reply differs from cause record");

    ss_wake_a: assert property ( // RULE6
        in_wait_state && wake_source_config_reg[4] && !serial_select_n && irq_in_n
            |=> !in_wait_state && wake_cause_record_reg[5:0] == 6'h10)
        else $error("serial-select wake missed");

    irq_wake_a: assert property ( // RULE7
        in_wait_state && wake_source_config_reg[3] && !irq_in_n
            |=> !in_wait_state && idle_reply_byte[5:0] == 6'h08)
        else $error("interrupt-pin wake missed");

    tag_wake_a: assert property ( // RULE8
        in_wait_state && trial && wake_source_config_reg[1] && !in_window
            && serial_select_n && irq_in_n |=> idle_reply_byte[5:0] == 6'h02)
        else $error("tag detection wake missed");

    window_no_tag_a: assert property ( // RULE18
        in_wait_state && in_window |=> !wake_cause_record_reg[1] || $stable(wake_cause_record_reg))
        else $error("tag reported inside threshold window");

    ref_period_a: assert property ( // RULE10
        ref_tick |-> lfo_tick && ref_cnt_reg == 9'(REF_PERIODS - 1))
        else $error("reference period not 256 oscillator periods");

    rate_div_a: assert property ( // RULE2
        lfo_tick |-> lfo_cnt_reg == (16'(LFO_DIV) << low_freq_osc_rate) - 16'h0001)
        else $error("oscillator divider ignores rate field");

    timeout_a: assert property ( // RULE9
        in_wait_state && timeout_hit && !tag_hit && serial_select_n && irq_in_n
            |=> idle_reply_valid && idle_reply_byte[5:0] == 6'h01)
        else $error("timeout wake missed");

    rate_copy_a: assert property ( // RULE20
        idle_reply_valid |-> idle_reply_byte[7:6] == low_freq_osc_rate
            && $onehot(idle_reply_byte[5:0]))
        else $error("cause record not one source plus rate");

    reply_code_a: assert property ( // RULE13
        idle_reply_valid |-> idle_reply_byte[5:0] inside {6'h01, 6'h02, 6'h08, 6'h10})
        else $error("illegal wake event code");

endmodule : wakeup_source_event_control

// ### rtl/wake_ctrl_pkg.sv
package wake_ctrl_pkg;

    // ------------------------------------------------------------
    // clock and low-frequency oscillator timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    localparam int unsigned LFO_BASE_HZ = 32_000;
    localparam int unsigned LFO_BASE_DIV = SYS_CLK_HZ / LFO_BASE_HZ;
    localparam int unsigned REF_LFO_PERIODS = 256;

    // ------------------------------------------------------------
    // idle command framing (byte index 0 is the command code)
    // ------------------------------------------------------------
    localparam logic [7:0] IDLE_CODE = 8'h07;
    localparam int unsigned IDLE_LEN = 16;
    localparam logic [3:0] IDX_SOURCE = 4'h2;
    localparam logic [3:0] IDX_WAKE_PERIOD = 4'h9;
    localparam logic [3:0] IDX_LOWER_THR = 4'hC;
    localparam logic [3:0] IDX_UPPER_THR = 4'hD;
    localparam logic [3:0] IDX_SLEEP_LIMIT = 4'hF;

    // ------------------------------------------------------------
    // register indices for the register-read command
    // ------------------------------------------------------------
    localparam logic [1:0] REG_WAKE_SOURCE_CONFIG = 2'h0;
    localparam logic [1:0] REG_WAKE_CAUSE_RECORD = 2'h1;
    localparam logic [7:0] WAKE_SOURCE_CONFIG_RESET = 8'h00;
    localparam logic [7:0] WAKE_CAUSE_RECORD_RESET = 8'h00;

    // ------------------------------------------------------------
    // field layout shared by source and cause registers
    // ------------------------------------------------------------
    localparam int unsigned FLD_RATE_HI = 7;
    localparam int unsigned FLD_RATE_LO = 6;
    localparam int unsigned BIT_SS_PIN = 4;
    localparam int unsigned BIT_IRQ_PIN = 3;
    localparam int unsigned BIT_TAG = 1;
    localparam int unsigned BIT_TIMEOUT = 0;
    localparam logic [5:0] CAUSE_TIMEOUT = 6'h01;
    localparam logic [5:0] CAUSE_TAG = 6'h02;
    localparam logic [5:0] CAUSE_IRQ_PIN = 6'h08;
    localparam logic [5:0] CAUSE_SS_PIN = 6'h10;

    typedef enum logic {
        READY,
        WAIT_EVENT
    } pwr_state_type;

endpackage : wake_ctrl_pkg

// ### bench/host_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side: idle frames, register reads, threshold search
// ------------------------------------------------------------
module host_model (
    input wire logic sys_clk,
    output logic cmd_valid,
    output logic cmd_first,
    output logic [7:0] cmd_byte,
    output logic read_req,
    output logic [1:0] read_index,
    input wire logic in_wait_state,
    input wire logic idle_reply_valid,
    input wire logic [7:0] idle_reply_byte,
    input wire logic read_valid,
    input wire logic [7:0] read_data
);
    logic [7:0] frame [16];

    initial begin
        cmd_valid = 1'b0;
        cmd_first = 1'b0;
        cmd_byte = 8'h00;
        read_req = 1'b0;
        read_index = 2'h0;
    end

    task automatic send_frame(input logic [7:0] code, input logic [7:0] src,
        input logic [7:0] wp, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] lim);
        for (int i = 0; i < 16; i++) begin
            frame[i] = 8'hA5 ^ 8'(i);
        end
        frame[0] = code;
        frame[1] = 8'h0E;
        frame[wake_ctrl_pkg::IDX_SOURCE] = src;
        frame[wake_ctrl_pkg::IDX_WAKE_PERIOD] = wp;
        frame[wake_ctrl_pkg::IDX_LOWER_THR] = lo;
        frame[wake_ctrl_pkg::IDX_UPPER_THR] = hi;
        frame[wake_ctrl_pkg::IDX_SLEEP_LIMIT] = lim;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            cmd_valid <= 1'b1;
            cmd_first <= (i == 0);
            cmd_byte <= frame[i];
        end
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_first <= 1'b0;
        // released byte lane shows the inverse, not a stale copy
        cmd_byte <= ~frame[15];
    endtask : send_frame

    task automatic wait_wake(output logic [7:0] ev, output int n, output logic w);
        ev = 8'hFF;
        w = 1'b1;
        n = 0;
        while (n < 5000) begin
            @(negedge sys_clk);
            n++;
            if (idle_reply_valid === 1'b1) begin
                ev = idle_reply_byte;
                w = in_wait_state;
                break;
            end
        end
    endtask : wait_wake

    task automatic read_reg(input logic [1:0] idx, output logic [7:0] data);
        @(posedge sys_clk);
        read_req <= 1'b1;
        read_index <= idx;
        @(posedge sys_clk);
        read_req <= 1'b0;
        read_index <= ~idx;
        @(negedge sys_clk);
        data = (read_valid === 1'b1) ? read_data : 8'hFF;
    endtask : read_reg

    task automatic trial(input logic [7:0] hi, output logic [5:0] cause);
        logic [7:0] ev;
        int n;
        logic w;
        // tag and timeout both enabled, one trial per command
        send_frame(wake_ctrl_pkg::IDLE_CODE, 8'h03,
            8'h00, 8'h00, hi, 8'h01);
        wait_wake(ev, n, w);
        cause = ev[5:0];
    endtask : trial

    task automatic calibrate(output logic [7:0] ref_level, output logic ok);
        logic [7:0] h, step;
        logic [5:0] c;
        trial(8'h00, c);
        ok = (c === wake_ctrl_pkg::CAUSE_TAG);
        h = 8'hFC;
        trial(h, c);
        ok = ok & (c === wake_ctrl_pkg::CAUSE_TIMEOUT);
        for (step = 8'h80; step >= 8'h04; step = step >> 1) begin
            h = (c === wake_ctrl_pkg::CAUSE_TIMEOUT) ? h - step : h + step;
            trial(h, c);
        end
        ref_level = (c === wake_ctrl_pkg::CAUSE_TAG) ? h : h - 8'h04;
    endtask : calibrate
endmodule : host_model

// ### bench/test_wakeup_source_event_control.sv
`timescale 1ns/1ps

module test_wakeup_source_event_control;
    logic sys_clk, nrst, cmd_valid, cmd_first, read_req, serial_select_n, irq_in_n;
    logic in_wait_state, idle_reply_valid, read_valid, ok, w;
    logic [7:0] cmd_byte, tag_level, idle_reply_byte, read_data, d, ev, src, rl;
    logic [1:0] read_index, low_freq_osc_rate;
    int err_total, samples_checked, cycle_cnt, n, span;

    // short oscillator and reference counts keep the run brief
    wakeup_source_event_control #(.LFO_DIV(4), .REF_PERIODS(4)) DUT (
        .sys_clk, .nrst, .cmd_valid, .cmd_first, .cmd_byte, .read_req, .read_index,
        .serial_select_n, .irq_in_n, .tag_level, .in_wait_state, .idle_reply_valid,
        .idle_reply_byte, .read_valid, .read_data, .low_freq_osc_rate
    );

    host_model u_host (
        .sys_clk, .cmd_valid, .cmd_first, .cmd_byte, .read_req, .read_index,
        .in_wait_state, .idle_reply_valid, .idle_reply_byte, .read_valid, .read_data
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic set_pins(input logic ss, input logic irq, input logic [7:0] level);
        @(posedge sys_clk);
        serial_select_n <= ss;
        irq_in_n <= irq;
        tag_level <= level;
    endtask : set_pins

    task automatic still_waiting();
        repeat (40) @(negedge sys_clk);
        check("wait state held", {7'h00, in_wait_state}, 8'h01);
    endtask : still_waiting

    always @(posedge sys_clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 20000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        err_total = 0;
        samples_checked = 0;
        cycle_cnt = 0;
        nrst = 1'b0;
        serial_select_n = 1'b1;
        irq_in_n = 1'b1;
        tag_level = 8'h00;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        check("rate at reset", {6'h00, low_freq_osc_rate}, 8'h00);
        // indices 2 and 3 are unmapped and must read as zero
        for (int i = 0; i < 4; i++) begin
            u_host.read_reg(2'(i), d);
            check("register at reset", d, 8'h00);
        end
        // -------------------------------------------------------
        // timeout wake at every oscillator rate
        // -------------------------------------------------------
        for (int r = 0; r < 4; r++) begin
            src = {2'(r), 6'h01};
            u_host.send_frame(wake_ctrl_pkg::IDLE_CODE, src,
                8'h01, 8'h00, 8'h00, 8'h02);
            u_host.wait_wake(ev, n, w);
            span = 64 << r;
            check("timeout span", {7'h00, n inside {[span:span + 3]}}, 8'h01);
            check("timeout reply", ev, src);
            check("wait at wake", {7'h00, w}, 8'h00);
            check("rate output", {6'h00, low_freq_osc_rate}, {6'h00, 2'(r)});
            u_host.read_reg(wake_ctrl_pkg::REG_WAKE_CAUSE_RECORD, d);
            check("cause record", d, src);
            u_host.read_reg(wake_ctrl_pkg::REG_WAKE_SOURCE_CONFIG, d);
            check("source config", d, src);
        end
        // level inside the window must not wake; the pin does
        set_pins(1'b1, 1'b1, 8'h80);
        u_host.send_frame(wake_ctrl_pkg::IDLE_CODE, 8'h3F, 8'h00, 8'h00, 8'hFF, 8'h1E);
        still_waiting();
        set_pins(1'b1, 1'b0, 8'h80);
        u_host.wait_wake(ev, n, w);
        check("irq pin wake", ev, 8'h08);
        u_host.read_reg(wake_ctrl_pkg::REG_WAKE_SOURCE_CONFIG, d);
        check("reserved bits", d, 8'h1B);
        // disabled irq and tag sources are ignored, serial select wakes
        set_pins(1'b1, 1'b0, 8'h00);
        u_host.send_frame(wake_ctrl_pkg::IDLE_CODE, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01);
        still_waiting();
        set_pins(1'b0, 1'b0, 8'h00);
        u_host.wait_wake(ev, n, w);
        check("select pin wake", ev, 8'h10);
        set_pins(1'b1, 1'b1, 8'h00);
        u_host.send_frame(8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01);
        repeat (4) @(negedge sys_clk);
        check("other frame", {7'h00, in_wait_state}, 8'h00);
        u_host.read_reg(wake_ctrl_pkg::REG_WAKE_SOURCE_CONFIG, d);
        check("source kept", d, 8'h10);
        // -------------------------------------------------------
        // threshold calibration, ending once on tag and once on timeout
        // -------------------------------------------------------
        for (int k = 0; k < 2; k++) begin
            set_pins(1'b1, 1'b1, (k == 0) ? 8'h63 : 8'h9E);
            u_host.calibrate(rl, ok);
            check("calibration codes", {7'h00, ok}, 8'h01);
            check("reference level", rl, (k == 0) ? 8'h60 : 8'h9C);
        end
        u_host.send_frame(wake_ctrl_pkg::IDLE_CODE, 8'h03,
            8'h00, rl - 8'h08, rl + 8'h08, 8'h1E);
        still_waiting();
        set_pins(1'b1, 1'b1, 8'hB0);
        u_host.wait_wake(ev, n, w);
        check("tag wake", ev, 8'h02);
        stop_test();
    end
endmodule : test_wakeup_source_event_control
